// ==== design/ilc_level_merge.sv ====
// One request level: merges enabled sources and picks the lowest-vector source
`timescale 1ns/100ps
module ilc_level_merge #(
  parameter int N = 4
) (
  input wire logic [N-1:0] i_src_req,
  input wire logic [N-1:0] i_src_en,
  output logic o_level_req,
  output logic [N-1:0] o_src_grant
);
  logic [N-1:0] act;
  assign act = i_src_req & i_src_en;
  assign o_level_req = |act;
  // Source 0 holds the lowest vector, so the lowest set bit wins
  assign o_src_grant = act & (~act + N'(1));
endmodule

// ==== design/ilc_pkg.sv ====
// Constants for the interrupt level control block
package ilc_pkg;
  localparam int ILC_LEVELS = 8;
  localparam logic [7:0] ILC_ADDR_LEVEL_MASK = 8'hDD;
  localparam logic [7:0] ILC_ADDR_SYSTEM_MODE = 8'hDE;
  localparam int ILC_SYM_GIE_BIT = 0;
  localparam int ILC_SYM_EXT_BIT = 1;
  localparam int ILC_SYM_FAST_LO = 2;
  localparam int ILC_SYM_FAST_HI = 4;
  localparam logic [7:0] ILC_SYM_RW_MASK = 8'h1F;
  localparam logic [1:0] ILC_SYM_LOW_RESET = 2'h0;
  localparam logic [7:0] ILC_PEND_RESET = 8'h00;
  localparam logic [7:0] ILC_MASK_RESET = 8'h00;
  localparam logic [2:0] ILC_FAST_RESET = 3'h0;
  localparam int ILC_SRC_L0 = 3;
  localparam int ILC_SRC_L1 = 1;
  localparam int ILC_SRC_L2 = 2;
  localparam int ILC_SRC_L3 = 4;
  localparam int ILC_SRC_L4 = 4;
  localparam int ILC_SRC_L5 = 4;
  localparam int ILC_SRC_L6 = 4;
  localparam int ILC_SRC_L7 = 4;
  typedef enum logic [1:0] {
    ILC_IDLE = 2'b00,
    ILC_SERVICE = 2'b01
  } ilc_state_e;
endpackage

// ==== design/ilc_top.sv ====
// Interrupt level control: global enable, level masks, priority and request to the core
// Functional notes
// - Service needs global, mask, priority, source enable
// - System mode bit 0 is global enable
// - Reset clears system mode bits 1,0
// - Bits 4:2 fast level, reset value undefined; here reset loads ILC_FAST_RESET (0)
// - System mode register at DEH
// - Mask bit n gates level n
// - Mask undefined at reset, software writes; here reset clears it to ILC_MASK_RESET (0)
// - Mask register at DDH, read/write
// - Level0 timer A events, level1 timer B
// - Level2 timer 0 overflow and match
// - Level3 timer 1 and 2 events
// - Level4 detector, watch timer, SPI, I2C
// - Level5 both UART transmit and receive
// - Read-only pending register, reset cleared
// - Lowest vector source wins within level
// - Accept clears enable, return sets it
`timescale 1ns/100ps
module ilc_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  input wire logic I_GLOBAL_ENABLE_INSTR,
  input wire logic I_GLOBAL_DISABLE_INSTR,
  input wire logic I_INTERRUPT_RETURN_INSTR,
  input wire logic I_IACK,
  input wire logic [ilc_pkg::ILC_LEVELS-1:0] I_LEVEL_PRIORITY_OK,
  input wire logic [3:0] I_SRC_L0,
  input wire logic [3:0] I_EN_L0,
  input wire logic [3:0] I_SRC_L1,
  input wire logic [3:0] I_EN_L1,
  input wire logic [3:0] I_SRC_L2,
  input wire logic [3:0] I_EN_L2,
  input wire logic [3:0] I_SRC_L3,
  input wire logic [3:0] I_EN_L3,
  input wire logic [3:0] I_SRC_L4,
  input wire logic [3:0] I_EN_L4,
  input wire logic [3:0] I_SRC_L5,
  input wire logic [3:0] I_EN_L5,
  input wire logic [3:0] I_SRC_L6,
  input wire logic [3:0] I_EN_L6,
  input wire logic [3:0] I_SRC_L7,
  input wire logic [3:0] I_EN_L7,
  output logic O_CPU_IRQ,
  output logic [ilc_pkg::ILC_LEVELS-1:0] O_PENDING,
  output logic [ilc_pkg::ILC_LEVELS-1:0] O_SERVICE_LEVEL,
  output logic [31:0] O_SRC_GRANT,
  output logic [2:0] O_FAST_LEVEL,
  output logic O_IN_SERVICE
);
  import ilc_pkg::*;

  localparam int W = 4;
  logic [31:0] src_all;
  logic [31:0] en_all;
  logic [31:0] grant_all;
  logic [31:0] pick_wide;
  logic [ILC_LEVELS-1:0] level_req;
  logic [ILC_LEVELS-1:0] mask_q;
  logic [ILC_LEVELS-1:0] pend_q;
  logic gie_q;
  logic ext_q;
  logic [2:0] fast_q;
  logic [ILC_LEVELS-1:0] eligible;
  logic [ILC_LEVELS-1:0] pick;
  logic [ILC_LEVELS-1:0] svc_lvl_q;
  logic [31:0] svc_src_q;
  logic [7:0] rdata_q;
  ilc_state_e state_q;
  logic wr_sym;
  logic wr_mask;

  // Unused source slots of narrow levels are tied off by the integrator
  assign src_all = {I_SRC_L7, I_SRC_L6, I_SRC_L5, I_SRC_L4, I_SRC_L3, I_SRC_L2, I_SRC_L1, I_SRC_L0};
  assign en_all = {I_EN_L7, I_EN_L6, I_EN_L5, I_EN_L4, I_EN_L3, I_EN_L2, I_EN_L1, I_EN_L0};

  genvar g;
  generate
    for (g = 0; g < ILC_LEVELS; g++) begin : g_lvl
      ilc_level_merge #(.N(W)) u_merge (
        .i_src_req(src_all[g*W +: W]),
        .i_src_en(en_all[g*W +: W]),
        .o_level_req(level_req[g]),
        .o_src_grant(grant_all[g*W +: W])
      );
      // Only the accepted level's grant is kept, other levels may also hold winners
      assign pick_wide[g*W +: W] = {W{pick[g]}};
    end
  endgenerate

  assign wr_sym = I_REG_WR && (I_REG_ADDR == ILC_ADDR_SYSTEM_MODE);
  assign wr_mask = I_REG_WR && (I_REG_ADDR == ILC_ADDR_LEVEL_MASK);

  // Pending mirrors enabled source activity; cleared by reset
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_q <= ILC_PEND_RESET;
    end else begin
      pend_q <= level_req;
    end
  end

  // Mask has no defined reset in the part; zero chosen so nothing fires early
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mask_q <= ILC_MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= I_REG_WDATA;
    end
  end

  // Acceptance and disable win over enable and return in the same cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gie_q <= ILC_SYM_LOW_RESET[ILC_SYM_GIE_BIT];
      ext_q <= ILC_SYM_LOW_RESET[ILC_SYM_EXT_BIT];
    end else begin
      if (wr_sym) begin
        ext_q <= I_REG_WDATA[ILC_SYM_EXT_BIT];
      end
      if (I_IACK && O_CPU_IRQ) begin
        gie_q <= 1'b0;
      end else if (I_GLOBAL_DISABLE_INSTR) begin
        gie_q <= 1'b0;
      end else if (I_GLOBAL_ENABLE_INSTR || I_INTERRUPT_RETURN_INSTR) begin
        gie_q <= 1'b1;
      end else if (wr_sym) begin
        gie_q <= I_REG_WDATA[ILC_SYM_GIE_BIT];
      end
    end
  end

  // Undefined in the part; a constant is used as async reset must be constant
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fast_q <= ILC_FAST_RESET;
    end else if (wr_sym) begin
      fast_q <= I_REG_WDATA[ILC_SYM_FAST_HI:ILC_SYM_FAST_LO];
    end
  end

  assign eligible = pend_q & mask_q & I_LEVEL_PRIORITY_OK;
  assign pick = eligible & (~eligible + ILC_LEVELS'(1));
  assign O_CPU_IRQ = gie_q && (|eligible);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= ILC_IDLE;
      svc_lvl_q <= ILC_PEND_RESET;
      svc_src_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        ILC_IDLE: begin
          if (I_IACK && O_CPU_IRQ) begin
            state_q <= ILC_SERVICE;
            svc_lvl_q <= pick;
            svc_src_q <= grant_all & pick_wide;
          end
        end
        ILC_SERVICE: begin
          if (I_INTERRUPT_RETURN_INSTR) begin
            state_q <= ILC_IDLE;
          end
        end
        default: state_q <= ILC_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q <= '0;
    end else if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        ILC_ADDR_LEVEL_MASK: rdata_q <= mask_q;
        ILC_ADDR_SYSTEM_MODE: rdata_q <= {3'h0, fast_q, ext_q, gie_q} & ILC_SYM_RW_MASK;
        default: rdata_q <= '0;
      endcase
    end
  end

  assign O_REG_RDATA = rdata_q;
  assign O_PENDING = pend_q;
  assign O_SERVICE_LEVEL = svc_lvl_q;
  assign O_SRC_GRANT = svc_src_q;
  assign O_FAST_LEVEL = fast_q;
  assign O_IN_SERVICE = (state_q == ILC_SERVICE);

  property p_irq_needs_gie;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N) O_CPU_IRQ |-> gie_q && |(pend_q & mask_q);
  endproperty
  a_irq_needs_gie: assert property (p_irq_needs_gie) else $error("request without enable");

  property p_ack_clears;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N) (I_IACK && O_CPU_IRQ) |=> !gie_q;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("accept left enable set");

  property p_ei_sets;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      (I_GLOBAL_ENABLE_INSTR && !I_GLOBAL_DISABLE_INSTR && !I_IACK) |=> gie_q;
  endproperty
  a_ei_sets: assert property (p_ei_sets) else $error("enable instruction ignored");

  property p_di_clears;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N) I_GLOBAL_DISABLE_INSTR |=> !gie_q;
  endproperty
  a_di_clears: assert property (p_di_clears) else $error("disable instruction ignored");

  property p_mask_write;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N) wr_mask |=> mask_q == $past(I_REG_WDATA);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_masked_quiet;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N) (mask_q == '0) |-> !O_CPU_IRQ;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked level requested");

  property p_pend_follow;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N) 1'b1 |=> pend_q == $past(level_req);
  endproperty
  a_pend_follow: assert property (p_pend_follow) else $error("pending wrong");

  property p_fast_write;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
      wr_sym |=> fast_q == $past(I_REG_WDATA[ILC_SYM_FAST_HI:ILC_SYM_FAST_LO]);
  endproperty
  a_fast_write: assert property (p_fast_write) else $error("fast level write lost");

  sequence s_accept;
    I_IACK && O_CPU_IRQ && state_q == ILC_IDLE;
  endsequence
  sequence s_in_service;
    O_IN_SERVICE && (O_SERVICE_LEVEL == $past(pick));
  endsequence
  property p_service;
    @(posedge I_CORE_CLK) disable iff (!I_RST_N) s_accept |=> s_in_service;
  endproperty
  a_service: assert property (p_service) else $error("service level wrong");
endmodule

// ==== tb/ilc_cpu_model.sv ====
// Core sequencer model: acknowledges a request, then returns after a delay
`timescale 1ns/100ps
module ilc_cpu_model (
  input wire logic i_clk,
  input wire logic i_irq,
  input wire logic i_auto,
  input wire logic [3:0] i_delay,
  output logic o_iack,
  output logic o_interrupt_return_instr
);
  int cnt = 0;
  // Acks only while a request stands, so a stray ack is never sent
  // Driven on the rising edge so the bench's falling-edge stimulus never races it
  always @(posedge i_clk) begin
    o_iack <= 1'b0;
    o_interrupt_return_instr <= 1'b0;
    if (cnt == 1) begin
      o_interrupt_return_instr <= 1'b1;
    end
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (i_auto && i_irq === 1'b1) begin
      o_iack <= 1'b1;
      cnt <= int'(i_delay) + 1;
    end
  end
endmodule

// ==== tb/ilc_top_tb_top.sv ====
// Testbench for the interrupt level control block
`timescale 1ns/100ps
module ilc_top_tb_top;
  import ilc_pkg::*;
  logic clk, rst_n, wr, rd, ei, di, auto, irq, iack, interrupt_return_instr, insvc;
  logic [7:0] addr, wdata, rdata, pri, pend, svc;
  logic [3:0] src [8];
  logic [3:0] en [8];
  logic [31:0] grant;
  logic [2:0] fast;
  int mismatches = 0;
  int compares = 0;
  ilc_top dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_GLOBAL_ENABLE_INSTR(ei),
    .I_GLOBAL_DISABLE_INSTR(di), .I_INTERRUPT_RETURN_INSTR(interrupt_return_instr), .I_IACK(iack),
    .I_LEVEL_PRIORITY_OK(pri), .I_SRC_L0(src[0]), .I_EN_L0(en[0]), .I_SRC_L1(src[1]),
    .I_EN_L1(en[1]), .I_SRC_L2(src[2]), .I_EN_L2(en[2]), .I_SRC_L3(src[3]), .I_EN_L3(en[3]),
    .I_SRC_L4(src[4]), .I_EN_L4(en[4]), .I_SRC_L5(src[5]), .I_EN_L5(en[5]), .I_SRC_L6(src[6]),
    .I_EN_L6(en[6]), .I_SRC_L7(src[7]), .I_EN_L7(en[7]), .O_CPU_IRQ(irq), .O_PENDING(pend),
    .O_SERVICE_LEVEL(svc), .O_SRC_GRANT(grant), .O_FAST_LEVEL(fast), .O_IN_SERVICE(insvc));
  ilc_cpu_model cpu (.i_clk(clk), .i_irq(irq), .i_auto(auto), .i_delay(4'h3), .o_iack(iack), .o_interrupt_return_instr(interrupt_return_instr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {rst_n, wr, rd, ei, di, auto} = 6'h0;
    addr = 8'h00;
    wdata = 8'h00;
    pri = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      src[i] = 4'h0;
      en[i] = 4'h0;
    end
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    rreg(ILC_ADDR_SYSTEM_MODE, 8'h00);
    chk(pend, 8'h00);
    wreg(ILC_ADDR_LEVEL_MASK, 8'hA5);
    rreg(ILC_ADDR_LEVEL_MASK, 8'hA5);
    wreg(ILC_ADDR_SYSTEM_MODE, 8'hFF);
    rreg(ILC_ADDR_SYSTEM_MODE, 8'h1F);
    chk(fast, 3'h7);
    wreg(8'hC0, 8'hFF);
    rreg(8'hC0, 8'h00);
    wreg(ILC_ADDR_SYSTEM_MODE, 8'h00);
    rreg(ILC_ADDR_SYSTEM_MODE, 8'h00);
    chk(fast, 3'h0);
    wreg(ILC_ADDR_LEVEL_MASK, 8'h00);
    // Every level: a disabled source stays quiet, an enabled one pends on its own bit
    for (int n = 0; n < 8; n++) begin
      src[n] = 4'h1;
      @(negedge clk);
      chk(pend, 8'h00);
      en[n] = 4'h1;
      @(negedge clk);
      chk(pend, 8'h01 << n);
      chk(irq, 1'b0);
      src[n] = 4'h0;
      en[n] = 4'h0;
    end
    src[2] = 4'h2;
    en[2] = 4'h2;
    @(negedge clk);
    ei = 1'b1;
    @(negedge clk);
    ei = 1'b0;
    chk(irq, 1'b0);
    wreg(ILC_ADDR_LEVEL_MASK, 8'h04);
    chk(irq, 1'b1);
    pri = 8'hFB;
    #1 chk(irq, 1'b0);
    @(negedge clk);
    pri = 8'hFF;
    di = 1'b1;
    @(negedge clk);
    di = 1'b0;
    chk(irq, 1'b0);
    ei = 1'b1;
    @(negedge clk);
    ei = 1'b0;
    chk(irq, 1'b1);
    // Two levels and two sources compete; level 2 source 1 must win
    src[2] = 4'hA;
    en[2] = 4'hF;
    src[3] = 4'hC;
    en[3] = 4'hF;
    wreg(ILC_ADDR_LEVEL_MASK, 8'h0C);
    auto = 1'b1;
    for (int k = 0; k < 20 && insvc !== 1'b1; k++) @(negedge clk);
    auto = 1'b0;
    chk(svc, 8'h04);
    chk(grant, 32'h0000_0200);
    chk(irq, 1'b0);
    rreg(ILC_ADDR_SYSTEM_MODE, 8'h00);
    for (int k = 0; k < 20 && insvc !== 1'b0; k++) @(negedge clk);
    rreg(ILC_ADDR_SYSTEM_MODE, 8'h01);
    chk(irq, 1'b1);
    tally_and_finish();
  end
endmodule
